//--- logic/adc_device.sv
// converter end: power modes, ready flag, output word
// What this block does
// - power-up leaves block active
// - two start pulses, clock low: nap
// - four start pulses, clock low: sleep
// - nap keeps reference powered
// - sleep powers everything down
// - clock rising edge wakes block
// - nap wake ready within 350ns
// - host waits reference ramp after sleep; adc_host does not wait, flag reads low during ramp
// - ready flag only once reference settled
// - ready flag shifted before result bits
// - low reference pin forces flag low
// - negative supply below ground selects bipolar
// - unipolar result is straight binary
// - bipolar result is two's complement
// - start rising edge resets SAR, converts
// - output updates on clock rising edge
// - 50ns clock pulse wakes block
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_device
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    adc_link_if.device link,
    input wire logic [11:0] sample_code,
    input wire logic vss_below_gnd,
    input wire logic ref_pin_low,
    output logic reference_powered,
    output logic analog_powered,
    output logic bipolar_mode,
    output logic reference_ready_flag,
    output logic converting
);
    logic [1:0] sclk_s, conversion_start_s, vss_s, ref_s;
    power_mode_t mode_reg, mode_next;
    logic [2:0] pulse_cnt_reg, pulse_cnt_next;
    logic sclk_d_reg, conversion_start_d_reg;
    logic [17:0] settle_reg, settle_next;
    logic settled_reg, settled_next;
    logic [16:0] shift_reg, shift_next;
    logic [4:0] bits_reg, bits_next;
    logic dout_reg, dout_next;
    logic ref_on_reg, ana_on_reg, bip_reg, rdy_reg;
    logic converting_reg;
    logic sclk_rise, conversion_start_rise;

    // input pins are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_s <= 2'h0;
            conversion_start_s <= 2'h0;
            vss_s <= 2'h0;
            ref_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[0], link.serial_clk};
            conversion_start_s <= {conversion_start_s[0], link.conversion_start};
            vss_s <= {vss_s[0], vss_below_gnd};
            ref_s <= {ref_s[0], ref_pin_low};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_d_reg;
    assign conversion_start_rise = conversion_start_s[1] & ~conversion_start_d_reg;

    // bipolar result as two's complement: offset binary with msb flipped
    function automatic result_t encode(input result_t raw, input logic bip);
        encode = bip ? {~raw[11], raw[10:0]} : raw;
    endfunction

    always_comb begin
        mode_next = mode_reg;
        pulse_cnt_next = pulse_cnt_reg;
        settle_next = settle_reg;
        settled_next = settled_reg;
        shift_next = shift_reg;
        bits_next = bits_reg;
        dout_next = dout_reg;
        // any clock rise breaks a mode sequence, so the count restarts
        if (sclk_rise) begin
            pulse_cnt_next = 3'h0;
        end else if (conversion_start_rise && !sclk_s[1] && pulse_cnt_reg != 3'h7) begin
            pulse_cnt_next = pulse_cnt_reg + 3'h1;
        end
        unique case (mode_reg)
            pwr_active: begin
                if (!sclk_s[1] && conversion_start_rise && pulse_cnt_reg == `SLEEP_PULSES - 3'h1) begin
                    mode_next = pwr_sleep;
                    settled_next = 1'b0;
                end else if (!sclk_s[1] && pulse_cnt_reg == `NAP_PULSES
                             && !conversion_start_s[1] && conversion_start_d_reg) begin
                    // nap taken at second pulse's fall; a fourth pulse continues to sleep
                    mode_next = pwr_nap;
                end
            end
            pwr_nap: begin
                if (sclk_rise) begin
                    mode_next = pwr_active;
                    settle_next = 18'(`NAP_WAKE_CYC);
                end else if (!sclk_s[1] && conversion_start_rise
                             && pulse_cnt_reg == `SLEEP_PULSES - 3'h1) begin
                    mode_next = pwr_sleep;
                    settled_next = 1'b0;
                end
            end
            pwr_sleep: begin
                if (sclk_rise) begin
                    mode_next = pwr_active;
                    settle_next = 18'(`SLEEP_RAMP_CYC);
                end
            end
            default: mode_next = pwr_active;
        endcase
        if (mode_reg == pwr_active) begin
            if (settle_reg != 18'h0) begin
                settle_next = settle_reg - 18'h1;
            end else begin
                settled_next = 1'b1;
            end
        end
        // conversion: start edge resets SAR and loads the word
        if (mode_reg == pwr_active && conversion_start_rise && sclk_s[1] == 1'b0 && bits_reg == 5'h0) begin
            shift_next = {1'b0, 3'h0, rdy_reg, encode(sample_code, bip_reg)};
            bits_next = 5'(`WORD_BITS);
        end else if (sclk_rise && bits_reg != 5'h0) begin
            dout_next = shift_reg[`WORD_BITS - 1];
            shift_next = {shift_reg[15:0], 1'b0};
            bits_next = bits_reg - 5'h1;
        end
        // the first mode pulse loads a word; drop it on power-down so that
        // a stale word does not block the first start after wake-up
        if (mode_next != pwr_active) begin
            bits_next = 5'h0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= pwr_active;
            pulse_cnt_reg <= 3'h0;
            sclk_d_reg <= 1'b0;
            conversion_start_d_reg <= 1'b0;
            settle_reg <= 18'h0;
            settled_reg <= 1'b1;
            shift_reg <= 17'h0;
            bits_reg <= 5'h0;
            dout_reg <= 1'b0;
            ref_on_reg <= 1'b1;
            ana_on_reg <= 1'b1;
            bip_reg <= 1'b0;
            rdy_reg <= 1'b0;
            converting_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            pulse_cnt_reg <= pulse_cnt_next;
            sclk_d_reg <= sclk_s[1];
            conversion_start_d_reg <= conversion_start_s[1];
            settle_reg <= settle_next;
            settled_reg <= settled_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            dout_reg <= dout_next;
            ref_on_reg <= (mode_next != pwr_sleep);
            ana_on_reg <= (mode_next == pwr_active);
            bip_reg <= vss_s[1];
            rdy_reg <= settled_next && mode_next == pwr_active && settle_next == 18'h0
                       && !ref_s[1];
            // registered copy so the output leaves a flip-flop
            converting_reg <= bits_next != 5'h0;
        end
    end

    assign link.serial_data_out = dout_reg;
    assign reference_powered = ref_on_reg;
    assign analog_powered = ana_on_reg;
    assign bipolar_mode = bip_reg;
    assign reference_ready_flag = rdy_reg;
    assign converting = converting_reg;
endmodule

//--- logic/adc_ctrl_regs.svh
// timing constants and field positions for the converter control block
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define CORE_CLK_NS 25
`define NAP_WAKE_NS 350
`define NAP_WAKE_CYC ((`NAP_WAKE_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SLEEP_RAMP_NS 4000000
`define SLEEP_RAMP_CYC ((`SLEEP_RAMP_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define WAKE_PULSE_NS 50
`define WAKE_PULSE_CYC ((`WAKE_PULSE_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define NAP_PULSES 3'h2
`define SLEEP_PULSES 3'h4
`define WORD_BITS 16
`define RDY_POS 12
`define RESULT_BITS 12
`define SCLK_HALF 4
`endif

//--- logic/adc_ctrl_pkg.sv
// types shared by both ends of the converter link
package adc_ctrl_pkg;
    typedef enum logic [1:0] {pwr_active, pwr_nap, pwr_sleep} power_mode_t;
    typedef logic [11:0] result_t;
endpackage

//--- logic/adc_link_if.sv
// three-wire link between host and converter
`timescale 1ns/1ps
interface adc_link_if;
    logic serial_clk;
    logic conversion_start;
    logic serial_data_out;
    modport device (input serial_clk, input conversion_start, output serial_data_out);
    modport host (output serial_clk, output conversion_start, input serial_data_out);
endinterface

//--- logic/adc_host.sv
// host end: drives serial clock and start, collects 16-bit words
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_host
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    adc_link_if.host link,
    input wire logic cmd_convert,
    input wire logic cmd_nap,
    input wire logic cmd_sleep,
    input wire logic cmd_wake,
    output logic busy,
    output logic word_valid,
    output logic [15:0] word_data
);
    typedef enum logic [2:0] {h_idle, h_pulse_hi, h_pulse_lo, h_wake, h_shift} hstate_t;
    hstate_t st_reg, st_next;
    logic [2:0] left_reg, left_next;
    logic [4:0] bits_reg, bits_next;
    logic [3:0] tick_reg, tick_next;
    logic sclk_reg, sclk_next, conversion_start_reg, conversion_start_next;
    logic [1:0] din_s;
    logic [15:0] data_reg, data_next;
    logic valid_reg, valid_next;
    logic busy_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            din_s <= 2'h0;
        end else begin
            din_s <= {din_s[0], link.serial_data_out};
        end
    end

    always_comb begin
        st_next = st_reg;
        left_next = left_reg;
        bits_next = bits_reg;
        tick_next = tick_reg;
        sclk_next = sclk_reg;
        conversion_start_next = conversion_start_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        if (tick_reg != 4'h0) begin
            tick_next = tick_reg - 4'h1;
        end
        unique case (st_reg)
            h_idle: begin
                sclk_next = 1'b0;
                if (cmd_convert) begin
                    conversion_start_next = 1'b1;
                    bits_next = 5'(`WORD_BITS);
                    tick_next = 4'(`SCLK_HALF);
                    st_next = h_shift;
                end else if (cmd_nap || cmd_sleep) begin
                    left_next = cmd_sleep ? `SLEEP_PULSES : `NAP_PULSES;
                    conversion_start_next = 1'b1;
                    tick_next = 4'(`SCLK_HALF);
                    st_next = h_pulse_hi;
                end else if (cmd_wake) begin
                    sclk_next = 1'b1;
                    tick_next = 4'(`WAKE_PULSE_CYC + 4);
                    st_next = h_wake;
                end
            end
            h_pulse_hi: if (tick_reg == 4'h0) begin
                conversion_start_next = 1'b0;
                left_next = left_reg - 3'h1;
                tick_next = 4'(`SCLK_HALF);
                st_next = h_pulse_lo;
            end
            h_pulse_lo: if (tick_reg == 4'h0) begin
                if (left_reg == 3'h0) begin
                    st_next = h_idle;
                end else begin
                    conversion_start_next = 1'b1;
                    tick_next = 4'(`SCLK_HALF);
                    st_next = h_pulse_hi;
                end
            end
            h_wake: if (tick_reg == 4'h0) begin
                sclk_next = 1'b0;
                st_next = h_idle;
            end
            h_shift: if (tick_reg == 4'h0) begin
                sclk_next = ~sclk_reg;
                tick_next = 4'(`SCLK_HALF);
                if (!sclk_reg) begin
                    conversion_start_next = 1'b0;
                    // sample the bit placed on the previous rising edge
                    if (bits_reg != 5'(`WORD_BITS)) begin
                        data_next = {data_reg[14:0], din_s[1]};
                    end
                    if (bits_reg == 5'h0) begin
                        valid_next = 1'b1;
                        sclk_next = 1'b0;
                        st_next = h_idle;
                    end else begin
                        bits_next = bits_reg - 5'h1;
                    end
                end
            end
            default: st_next = h_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= h_idle;
            left_reg <= 3'h0;
            bits_reg <= 5'h0;
            tick_reg <= 4'h0;
            sclk_reg <= 1'b0;
            conversion_start_reg <= 1'b0;
            data_reg <= 16'h0;
            valid_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            left_reg <= left_next;
            bits_reg <= bits_next;
            tick_reg <= tick_next;
            sclk_reg <= sclk_next;
            conversion_start_reg <= conversion_start_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            busy_reg <= st_next != h_idle;
        end
    end

    assign link.serial_clk = sclk_reg;
    assign link.conversion_start = conversion_start_reg;
    assign busy = busy_reg;
    assign word_valid = valid_reg;
    assign word_data = data_reg;
endmodule

//--- tb/adc_link_props.sv
// concurrent checks on the converter link and power state
`timescale 1ns/1ps
module adc_link_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic serial_clk,
    input wire logic conversion_start,
    input wire logic serial_data_out,
    input wire logic ref_pin_low,
    input wire logic reference_powered,
    input wire logic analog_powered,
    input wire logic reference_ready_flag,
    input wire logic converting
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic conversion_start_q;
    logic [2:0] pulse_cnt;
    logic [3:0] rise_age;
    // start pulses seen while the clock idles low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            conversion_start_q <= 1'b0;
            pulse_cnt <= 3'h0;
        end else begin
            conversion_start_q <= conversion_start;
            if (serial_clk) pulse_cnt <= 3'h0;
            else if (conversion_start && !conversion_start_q && pulse_cnt != 3'h7)
                pulse_cnt <= pulse_cnt + 3'h1;
        end
    end
    // cycles since the last clock rise, saturating
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) rise_age <= 4'hf;
        else if ($rose(serial_clk)) rise_age <= 4'h0;
        else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
    end
    property p_power_up;
        $rose(resetn) |-> analog_powered && reference_powered;
    endproperty
    property p_nap_entry;
        $fell(conversion_start) && !serial_clk && pulse_cnt == 3'h2
            |-> ##[1:8] (reference_powered && !analog_powered);
    endproperty
    property p_sleep_entry;
        $rose(conversion_start) && !serial_clk && pulse_cnt == 3'h3 |-> ##[1:8] !reference_powered;
    endproperty
    property p_sleep_all_off;
        !reference_powered |-> !analog_powered;
    endproperty
    property p_wake;
        $rose(serial_clk) && !analog_powered |-> ##[1:8] analog_powered;
    endproperty
    property p_flag_low_asleep;
        !reference_powered [*3] |-> !reference_ready_flag;
    endproperty
    property p_ref_low_forces;
        ref_pin_low [*4] |-> !reference_ready_flag;
    endproperty
    property p_start_converts;
        $rose(conversion_start) && !serial_clk && analog_powered && !converting
            |-> ##[1:6] converting;
    endproperty
    property p_dout_after_rise;
        $changed(serial_data_out) |-> rise_age <= 4'h7;
    endproperty
    a_power_up: assert property (p_power_up) else $error("not active after reset");
    a_nap_entry: assert property (p_nap_entry) else $error("nap not entered");
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    a_sleep_all_off: assert property (p_sleep_all_off) else $error("analog on");
    a_wake: assert property (p_wake) else $error("no wake on clock rise");
    a_flag_low_asleep: assert property (p_flag_low_asleep) else $error("flag high");
    a_ref_low_forces: assert property (p_ref_low_forces) else $error("flag not low");
    a_start_converts: assert property (p_start_converts) else $error("start ignored");
    a_dout_after_rise: assert property (p_dout_after_rise) else $error("dout late");
    c_nap: cover property (reference_powered && !analog_powered);
    c_sleep: cover property (!reference_powered);
    c_word: cover property ($fell(converting));
endmodule

//--- tb/tb_adc_power_mode_and_output_coding.sv
// self-checking bench: host and converter joined over the link
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module tb_adc_power_mode_and_output_coding;
    import adc_ctrl_pkg::*;
    logic core_clk, resetn, vss_below_gnd, ref_pin_low;
    logic [11:0] sample_code;
    logic cmd_convert, cmd_nap, cmd_sleep, cmd_wake, busy, word_valid;
    logic reference_powered, analog_powered, bipolar_mode, reference_ready_flag, converting;
    logic [15:0] word_data, word_seen;
    int err_total, cmp_count, cyc;
    adc_link_if adc_link_if_inst ();
    adc_host adc_host_inst (.core_clk(core_clk), .resetn(resetn), .link(adc_link_if_inst.host),
        .cmd_convert(cmd_convert), .cmd_nap(cmd_nap), .cmd_sleep(cmd_sleep),
        .cmd_wake(cmd_wake), .busy(busy), .word_valid(word_valid), .word_data(word_data));
    adc_device adc_device_inst (.core_clk(core_clk), .resetn(resetn),
        .link(adc_link_if_inst.device), .sample_code(sample_code),
        .vss_below_gnd(vss_below_gnd), .ref_pin_low(ref_pin_low),
        .reference_powered(reference_powered), .analog_powered(analog_powered),
        .bipolar_mode(bipolar_mode), .reference_ready_flag(reference_ready_flag),
        .converting(converting));
    adc_link_props adc_link_props_inst (.core_clk(core_clk), .resetn(resetn),
        .serial_clk(adc_link_if_inst.serial_clk),
        .conversion_start(adc_link_if_inst.conversion_start),
        .serial_data_out(adc_link_if_inst.serial_data_out), .ref_pin_low(ref_pin_low),
        .reference_powered(reference_powered), .analog_powered(analog_powered),
        .reference_ready_flag(reference_ready_flag), .converting(converting));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one-cycle request, then wait until the host has been idle three samples
    task automatic issue(input int which);
        int n, idle;
        n = 0;
        idle = 0;
        @(posedge core_clk) #2;
        {cmd_convert, cmd_nap, cmd_sleep, cmd_wake} = 4'h8 >> which;
        @(posedge core_clk) #2;
        {cmd_convert, cmd_nap, cmd_sleep, cmd_wake} = 4'h0;
        while (n < 400 && idle < 3) begin
            if (word_valid === 1'b1) word_seen = word_data;
            idle = (busy === 1'b0) ? idle + 1 : 0;
            n++;
            @(posedge core_clk) #2;
        end
        chk("host idle", {15'h0, idle >= 3}, 16'h0001);
    endtask
    task automatic conversion_start_case(input logic [11:0] code, input logic [15:0] exp);
        sample_code = code;
        word_seen = 16'hxxxx;
        issue(0);
        chk("word", word_seen, exp);
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (20) @(posedge core_clk);
        #2 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        #2 chk("powered", {14'h0, analog_powered, reference_powered}, 16'h0003);
    endtask
    task automatic t_unipolar();
        chk("bipolar", {15'h0, bipolar_mode}, 16'h0000);
        conversion_start_case(12'habc, 16'h1abc);
        conversion_start_case(12'hfff, 16'h1fff);
        conversion_start_case(12'h000, 16'h1000);
    endtask
    task automatic t_bipolar();
        vss_below_gnd = 1'b1;
        repeat (6) @(posedge core_clk);
        #2 chk("bipolar", {15'h0, bipolar_mode}, 16'h0001);
        conversion_start_case(12'h800, 16'h1000);
        conversion_start_case(12'h7ff, 16'h1fff);
        conversion_start_case(12'hfff, 16'h17ff);
        vss_below_gnd = 1'b0;
        repeat (6) @(posedge core_clk);
        #2 chk("bipolar", {15'h0, bipolar_mode}, 16'h0000);
    endtask
    task automatic t_ref_low();
        ref_pin_low = 1'b1;
        repeat (6) @(posedge core_clk);
        #2 chk("flag", {15'h0, reference_ready_flag}, 16'h0000);
        conversion_start_case(12'h123, 16'h0123);
        ref_pin_low = 1'b0;
    endtask
    task automatic t_nap();
        issue(1);
        chk("nap", {14'h0, analog_powered, reference_powered}, 16'h0001);
        issue(3);
        chk("wake", {15'h0, analog_powered}, 16'h0001);
        repeat (`NAP_WAKE_CYC) @(posedge core_clk);
        conversion_start_case(12'h055, 16'h1055);
    endtask
    task automatic t_sleep();
        issue(2);
        chk("sleep", {14'h0, analog_powered, reference_powered}, 16'h0000);
        issue(3);
        chk("wake", {15'h0, analog_powered}, 16'h0001);
        // ramp far from done, so the flag must still read low
        conversion_start_case(12'h0aa, 16'h00aa);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {cmd_convert, cmd_nap, cmd_sleep, cmd_wake} = 4'h0;
        {vss_below_gnd, ref_pin_low} = 2'h0;
        sample_code = 12'h000;
        do_reset();
        t_unipolar();
        t_bipolar();
        t_ref_low();
        t_nap();
        t_sleep();
        do_reset();
        conversion_start_case(12'h321, 16'h1321);
        end_of_test();
    end
endmodule
